/* msz_decode.sv */
// Combinational decode of the two size registers into byte capacities
`timescale 1ns/1ps
module msz_decode (
    // Register contents
    input  wire logic [7:0]        i_rom_ram,
    input  wire logic [7:0]        i_exp_ram,
    // Decoded capacities
    output msz_pkg::msz_caps_s     o_caps
);
    import msz_pkg::*;

    // Decode every field; illegal codes report zero bytes and clear ok
    always_comb begin
        o_caps = '0;
        // High-speed RAM field
        if (i_rom_ram[MSZ_HS_MSB:MSZ_HS_LSB] == MSZ_HS_1K) begin
            o_caps.hs_bytes = MSZ_BYTES_1K;
            o_caps.hs_ok    = 1'b1;
        end
        // Code store field
        unique case (i_rom_ram[MSZ_CODE_MSB:MSZ_CODE_LSB])
            MSZ_ROM_32K: begin
                o_caps.rom_bytes = MSZ_BYTES_32K;
                o_caps.rom_ok    = 1'b1;
            end
            MSZ_ROM_48K: begin
                o_caps.rom_bytes = MSZ_BYTES_48K;
                o_caps.rom_ok    = 1'b1;
            end
            MSZ_ROM_60K: begin
                o_caps.rom_bytes = MSZ_BYTES_60K;
                o_caps.rom_ok    = 1'b1;
            end
            default: begin
                // Prohibited code, no capacity claimed
                o_caps.rom_ok = 1'b0;
            end
        endcase
        // Expansion RAM field
        unique case (i_exp_ram[MSZ_EXP_MSB:MSZ_EXP_LSB])
            MSZ_EXP_0: begin
                o_caps.exp_bytes = MSZ_BYTES_0;
                o_caps.exp_ok    = 1'b1;
            end
            MSZ_EXP_1K: begin
                o_caps.exp_bytes = MSZ_BYTES_1K;
                o_caps.exp_ok    = 1'b1;
            end
            MSZ_EXP_2K: begin
                o_caps.exp_bytes = MSZ_BYTES_2K;
                o_caps.exp_ok    = 1'b1;
            end
            MSZ_EXP_4K: begin
                o_caps.exp_bytes = MSZ_BYTES_4K;
                o_caps.exp_ok    = 1'b1;
            end
            MSZ_EXP_6K: begin
                o_caps.exp_bytes = MSZ_BYTES_6K;
                o_caps.exp_ok    = 1'b1;
            end
            default: begin
                // Prohibited code
                o_caps.exp_ok = 1'b0;
            end
        endcase
    end

endmodule : msz_decode

/* msz_pkg.sv */
// Package for the memory size switching registers: map, fields, resets, codes, carriers
package msz_pkg;

    // Register addresses on the CPU memory bus
    localparam logic [15:0] MSZ_ADDR_ROM_RAM = 16'hfff0;
    localparam logic [15:0] MSZ_ADDR_EXP_RAM = 16'hfff4;

    // Values after reset
    localparam logic [7:0] MSZ_RST_ROM_RAM = 8'hcf;
    localparam logic [7:0] MSZ_RST_EXP_RAM = 8'h0c;

    // Writable bit masks; other positions are fixed at zero
    localparam logic [7:0] MSZ_MASK_ROM_RAM = 8'hef;
    localparam logic [7:0] MSZ_MASK_EXP_RAM = 8'h1f;

    // Field positions
    localparam int MSZ_HS_LSB   = 5;
    localparam int MSZ_HS_MSB   = 7;
    localparam int MSZ_CODE_LSB = 0;
    localparam int MSZ_CODE_MSB = 3;
    localparam int MSZ_EXP_LSB  = 0;
    localparam int MSZ_EXP_MSB  = 4;

    // High-speed RAM code
    localparam logic [2:0] MSZ_HS_1K = 3'h6;

    // Code store size codes
    localparam logic [3:0] MSZ_ROM_32K = 4'h8;
    localparam logic [3:0] MSZ_ROM_48K = 4'hc;
    localparam logic [3:0] MSZ_ROM_60K = 4'hf;

    // Expansion RAM codes
    localparam logic [4:0] MSZ_EXP_0    = 5'h0c;
    localparam logic [4:0] MSZ_EXP_1K   = 5'h0a;
    localparam logic [4:0] MSZ_EXP_2K   = 5'h08;
    localparam logic [4:0] MSZ_EXP_4K   = 5'h04;
    localparam logic [4:0] MSZ_EXP_6K   = 5'h00;

    // Capacities in bytes
    localparam logic [16:0] MSZ_BYTES_0   = 17'h00000;
    localparam logic [16:0] MSZ_BYTES_1K  = 17'h00400;
    localparam logic [16:0] MSZ_BYTES_2K  = 17'h00800;
    localparam logic [16:0] MSZ_BYTES_4K  = 17'h01000;
    localparam logic [16:0] MSZ_BYTES_6K  = 17'h01800;
    localparam logic [16:0] MSZ_BYTES_32K = 17'h08000;
    localparam logic [16:0] MSZ_BYTES_48K = 17'h0c000;
    localparam logic [16:0] MSZ_BYTES_60K = 17'h0f000;

    // CPU byte access carrier
    typedef struct packed {
        logic        wr;    // One-cycle byte write strobe
        logic        rd;    // One-cycle byte read strobe
        logic [15:0] addr;  // Memory address
        logic [7:0]  wdata; // Write byte
    } msz_bus_s;

    // Decoded capacities, with a legal flag per field
    typedef struct packed {
        logic [16:0] rom_bytes;
        logic        rom_ok;
        logic [16:0] hs_bytes;
        logic        hs_ok;
        logic [16:0] exp_bytes;
        logic        exp_ok;
    } msz_caps_s;

endpackage : msz_pkg

/* msz_regs.sv */
// Memory size switching register bank: two byte registers and decoded capacities
`timescale 1ns/1ps
module msz_regs (
    // Clock and reset
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst_n,
    // CPU byte access
    input  wire msz_pkg::msz_bus_s   i_bus,
    // Read answer
    output logic [7:0]               o_rdata,
    output logic                     o_rvalid,
    // Register contents
    output logic [7:0]               o_rom_ram_size_select,
    output logic [7:0]               o_expansion_ram_size_select,
    // Decoded capacities for address decode
    output msz_pkg::msz_caps_s       o_caps
);
    import msz_pkg::*;

    // All state of the block except the reset synchroniser in one record
    typedef struct packed {
        logic [7:0]  rom_ram;   // rom_ram_size_select
        logic [7:0]  exp_ram;   // expansion_ram_size_select
        logic [7:0]  rdata;     // Read data
        logic        rvalid;    // Read answer strobe
        msz_caps_s   caps;      // Registered capacities
    } msz_state_s;

    msz_state_s state_r;   // Registered state
    msz_state_s state_nxt; // Next state
    msz_caps_s  caps_now;  // Decode of the next register values
    logic [1:0] rst_sync_r; // Reset release synchroniser, kept apart so one process drives it
    logic       rst_n;     // Synchronised reset
    logic       hit_rr;    // Access to ROM/RAM register
    logic       hit_xr;    // Access to expansion register

    // Synchronised reset: asserted asynchronously, released after two edges
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Address decode, full 16-bit match
    assign hit_rr = (i_bus.addr == MSZ_ADDR_ROM_RAM);
    assign hit_xr = (i_bus.addr == MSZ_ADDR_EXP_RAM);

    // Decode of the values that will be registered, so outputs stay aligned
    msz_decode u_decode (
        .i_rom_ram (state_nxt.rom_ram),
        .i_exp_ram (state_nxt.exp_ram),
        .o_caps    (caps_now)
    );

    // Next-state logic
    always_comb begin
        state_nxt          = state_r;
        state_nxt.rvalid   = 1'b0;
        state_nxt.rdata    = 8'h00;
        // Whole-byte writes; fixed-zero bits masked so they never store
        if (i_bus.wr && hit_rr) begin
            state_nxt.rom_ram = i_bus.wdata & MSZ_MASK_ROM_RAM;
        end
        if (i_bus.wr && hit_xr) begin
            state_nxt.exp_ram = i_bus.wdata & MSZ_MASK_EXP_RAM;
        end
        // Reads answer one cycle later; unmapped addresses read zero
        if (i_bus.rd) begin
            state_nxt.rvalid = 1'b1;
            if (hit_rr) begin
                state_nxt.rdata = state_r.rom_ram & MSZ_MASK_ROM_RAM;
            end else if (hit_xr) begin
                state_nxt.rdata = state_r.exp_ram & MSZ_MASK_EXP_RAM;
            end
        end
        // Capacities follow the stored codes
        state_nxt.caps = caps_now;
    end

    // State register; reset values are constants
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r.rom_ram <= MSZ_RST_ROM_RAM;
            state_r.exp_ram <= MSZ_RST_EXP_RAM;
            state_r.rdata   <= 8'h00;
            state_r.rvalid  <= 1'b0;
            // Decode of the reset values: 60 KB, 1 KB, 0 bytes
            state_r.caps    <= '{rom_bytes: MSZ_BYTES_60K, rom_ok: 1'b1,
                                 hs_bytes:  MSZ_BYTES_1K,  hs_ok:  1'b1,
                                 exp_bytes: MSZ_BYTES_0,   exp_ok: 1'b1};
        end else begin
            state_r.rom_ram <= state_nxt.rom_ram;
            state_r.exp_ram <= state_nxt.exp_ram;
            state_r.rdata   <= state_nxt.rdata;
            state_r.rvalid  <= state_nxt.rvalid;
            state_r.caps    <= state_nxt.caps;
        end
    end

    // Outputs straight from flip-flops
    assign o_rom_ram_size_select       = state_r.rom_ram;
    assign o_expansion_ram_size_select = state_r.exp_ram;
    assign o_rdata                     = state_r.rdata;
    assign o_rvalid                    = state_r.rvalid;
    assign o_caps                      = state_r.caps;

    // Assertions
    property p_rr_write;
        @(posedge i_clk_sys) disable iff (!rst_n)
        (i_bus.wr && hit_rr) |=> (state_r.rom_ram == ($past(i_bus.wdata) & 8'hef));
    endproperty
    a_rr_write: assert property (p_rr_write) else $error("rom/ram write not stored");

    property p_xr_write;
        @(posedge i_clk_sys) disable iff (!rst_n)
        (i_bus.wr && hit_xr) |=> (state_r.exp_ram == ($past(i_bus.wdata) & 8'h1f));
    endproperty
    a_xr_write: assert property (p_xr_write) else $error("expansion write not stored");

    property p_rst_vals;
        @(posedge i_clk_sys) $rose(rst_n) |-> (state_r.rom_ram == 8'hcf && state_r.exp_ram == 8'h0c);
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("wrong reset values");

    property p_rr_read;
        @(posedge i_clk_sys) disable iff (!rst_n)
        (i_bus.rd && hit_rr && !i_bus.wr) |=> (o_rvalid && o_rdata == $past(state_r.rom_ram));
    endproperty
    a_rr_read: assert property (p_rr_read) else $error("rom/ram read wrong");

    property p_xr_read;
        @(posedge i_clk_sys) disable iff (!rst_n)
        (i_bus.rd && hit_xr) |=> (o_rvalid && o_rdata == $past(state_r.exp_ram));
    endproperty
    a_xr_read: assert property (p_xr_read) else $error("expansion read wrong");

    property p_zero_bits;
        @(posedge i_clk_sys) disable iff (!rst_n)
        (state_r.rom_ram[4] == 1'b0) && (state_r.exp_ram[7:5] == 3'b000);
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("fixed-zero bit set");

    property p_rom_cap;
        @(posedge i_clk_sys) disable iff (!rst_n)
        (state_r.rom_ram[3:0] == 4'hc) |-> (o_caps.rom_bytes == 17'h0c000 && o_caps.rom_ok);
    endproperty
    a_rom_cap: assert property (p_rom_cap) else $error("48 KB decode wrong");

    property p_exp_cap;
        @(posedge i_clk_sys) disable iff (!rst_n)
        (state_r.exp_ram[4:0] == 5'h00) |-> (o_caps.exp_bytes == 17'h01800 && o_caps.exp_ok);
    endproperty
    a_exp_cap: assert property (p_exp_cap) else $error("6144 byte decode wrong");

    property p_hs_cap;
        @(posedge i_clk_sys) disable iff (!rst_n)
        (state_r.rom_ram[7:5] != 3'b110) |-> (!o_caps.hs_ok && o_caps.hs_bytes == 17'h0);
    endproperty
    a_hs_cap: assert property (p_hs_cap) else $error("prohibited ram code accepted");

    property p_unmapped;
        @(posedge i_clk_sys) disable iff (!rst_n)
        (i_bus.rd && !hit_rr && !hit_xr) |=> (o_rvalid && o_rdata == 8'h00);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_cov_rr;
        @(posedge i_clk_sys) disable iff (!rst_n) i_bus.wr && hit_rr;
    endproperty
    c_cov_rr: cover property (p_cov_rr);

    property p_cov_xr;
        @(posedge i_clk_sys) disable iff (!rst_n) i_bus.wr && hit_xr;
    endproperty
    c_cov_xr: cover property (p_cov_xr);

    property p_cov_bad;
        @(posedge i_clk_sys) disable iff (!rst_n) !o_caps.rom_ok;
    endproperty
    c_cov_bad: cover property (p_cov_bad);

endmodule : msz_regs

/* tb_top.sv */
// Self-checking testbench for the memory size switching register bank
`timescale 1ns/1ps
module tb_top;
    import msz_pkg::*;

    // Stimulus tables: legal code store and expansion settings
    localparam logic [7:0]  ROM_V [3] = '{8'hc8, 8'hcc, 8'hcf};
    localparam logic [16:0] ROM_B [3] = '{MSZ_BYTES_32K, MSZ_BYTES_48K, MSZ_BYTES_60K};
    localparam logic [7:0]  EXP_V [5] = '{8'h0c, 8'h0a, 8'h08, 8'h04, 8'h00};
    localparam logic [16:0] EXP_B [5] = '{MSZ_BYTES_0, MSZ_BYTES_1K, MSZ_BYTES_2K, MSZ_BYTES_4K, MSZ_BYTES_6K};

    logic       clk_sys;      // System clock
    logic       rst_n;        // Reset, active low
    msz_bus_s   bus;          // CPU byte access
    logic [7:0] rdata;        // Read byte
    logic       rvalid;       // Read answer pulse
    logic [7:0] rom_ram;      // First register contents
    logic [7:0] exp_ram;      // Second register contents
    msz_caps_s  caps;         // Decoded capacities
    msz_caps_s  want;         // Expected capacities
    int         num_errors;   // Mismatches seen
    int         total_checks; // Comparisons made

    msz_regs i_dut (
        .i_clk_sys                   (clk_sys),
        .i_rst_n                     (rst_n),
        .i_bus                       (bus),
        .o_rdata                     (rdata),
        .o_rvalid                    (rvalid),
        .o_rom_ram_size_select       (rom_ram),
        .o_expansion_ram_size_select (exp_ram),
        .o_caps                      (caps)
    );

    // Clock generation, 5 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Byte comparison
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    // Capacity struct comparison
    task automatic chk_caps(input msz_caps_s exp);
        total_checks++;
        if (caps !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, caps, exp);
        end
    endtask : chk_caps

    // Drive one request at a falling edge; taken at the next rising edge
    task automatic access(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        bus <= '{wr: w, rd: r, addr: a, wdata: d};
    endtask : access

    // Idle the bus one falling edge later; prior request's answer is settled
    task automatic idle();
        @(negedge clk_sys);
        bus <= '0;
    endtask : idle

    // Full byte write
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        access(1'b1, 1'b0, a, d);
        idle();
    endtask : wr

    // Read and compare, including the one-cycle answer pulse
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        access(1'b0, 1'b1, a, 8'h00);
        idle();
        chk8({7'h0, rvalid}, 8'h01);
        chk8(rdata, exp);
        @(negedge clk_sys);
        chk8({7'h0, rvalid}, 8'h00);
    endtask : rd_chk

    // Reset for 8 cycles; released at a falling edge, then settle
    task automatic do_reset();
        rst_n = 1'b0;
        #1;
        chk8(rom_ram, MSZ_RST_ROM_RAM);
        chk8(exp_ram, MSZ_RST_EXP_RAM);
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        want = '{MSZ_BYTES_60K, 1'b1, MSZ_BYTES_1K, 1'b1, MSZ_BYTES_0, 1'b1};
    endtask : do_reset

    // Verdict, the single end of the run
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // Watchdog; the tests need under a hundred cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        num_errors++;
        final_report();
    end

    // Main sequence
    initial begin
        bus          = '0;
        // Held in reset from time zero so no unknown state reaches the assertions
        rst_n        = 1'b0;
        num_errors   = 0;
        total_checks = 0;
        @(negedge clk_sys);
        do_reset();
        chk_caps(want);
        rd_chk(MSZ_ADDR_ROM_RAM, 8'hcf);
        rd_chk(MSZ_ADDR_EXP_RAM, 8'h0c);
        // Every legal code store setting, ROM/RAM register before expansion
        for (int i = 0; i < 3; i++) begin
            wr(MSZ_ADDR_ROM_RAM, ROM_V[i]);
            want.rom_bytes = ROM_B[i];
            chk8(rom_ram, ROM_V[i]);
            chk_caps(want);
            rd_chk(MSZ_ADDR_ROM_RAM, ROM_V[i]);
        end
        // Every legal expansion setting
        for (int i = 0; i < 5; i++) begin
            wr(MSZ_ADDR_EXP_RAM, EXP_V[i]);
            want.exp_bytes = EXP_B[i];
            chk8(exp_ram, EXP_V[i]);
            chk_caps(want);
            rd_chk(MSZ_ADDR_EXP_RAM, EXP_V[i]);
        end
        // Fixed-zero bits and prohibited codes
        wr(MSZ_ADDR_ROM_RAM, 8'hff);
        want.hs_bytes = MSZ_BYTES_0;
        want.hs_ok    = 1'b0;
        chk8(rom_ram, 8'hef);
        chk_caps(want);
        wr(MSZ_ADDR_ROM_RAM, 8'hc7);
        want = '{MSZ_BYTES_0, 1'b0, MSZ_BYTES_1K, 1'b1, MSZ_BYTES_6K, 1'b1};
        chk_caps(want);
        wr(MSZ_ADDR_EXP_RAM, 8'hff);
        want.exp_bytes = MSZ_BYTES_0;
        want.exp_ok    = 1'b0;
        chk_caps(want);
        rd_chk(MSZ_ADDR_EXP_RAM, 8'h1f);
        // Back-to-back writes, second one with a read of the old value
        access(1'b1, 1'b0, MSZ_ADDR_ROM_RAM, 8'hc8);
        access(1'b1, 1'b1, MSZ_ADDR_ROM_RAM, 8'hcc);
        idle();
        want.rom_bytes = MSZ_BYTES_48K;
        want.rom_ok    = 1'b1;
        chk8(rdata, 8'hc8);
        chk8(rom_ram, 8'hcc);
        chk_caps(want);
        // Unmapped neighbours leave registers alone and read zero
        wr(16'hfff1, 8'h00);
        wr(16'hfff5, 8'hff);
        chk8(rom_ram, 8'hcc);
        chk8(exp_ram, 8'h1f);
        rd_chk(16'hfff2, 8'h00);
        // Reset in mid-run restores both registers
        do_reset();
        chk_caps(want);
        rd_chk(MSZ_ADDR_ROM_RAM, 8'hcf);
        final_report();
    end

endmodule : tb_top
